// ===== logic/crwi_pkg.sv
// Functional notes
// (R1) Reset pin low performs hardware reset; every control register returns to default.
// (R2) Reset pin pull-up enable is bit 1, default 1; pull-down is bit 0, default 0.
// (R3) Both pull enables set selects a bus keeper on the reset pin.
// (R4) With keeper active, reset input keeps its last level while the line floats.
// (R5) Far side resets the multidrop audio bus before asserting the reset pin.
// (R6) Any write to register zero triggers a software reset of most registers; the code ignores writes during pin reset or sleep.
// (R7) Software reset leaves the sequencer memory and its user sequences intact.
// (R8) Only a first access via another control interface may fail after soft reset.
// (R9) Sleep whenever analog and I/O supplies are up but core supply is low.
// (R10) Sleep holds core in reset; always-on registers survive; wake acts as soft reset.
// (R11) Sequencer memory reverts on power-on, hardware reset or sleep entry.
// (R12) Firmware memory clears on power-on, hardware reset or sleep, not soft reset.
// (R13) Boot-complete flags stay low during hardware reset, software reset and sleep.
// (R14) Boot sequence runs after every reset or wake; flags rise when it ends.
// (R15) Host should not write control registers until boot-complete reads as set.
// (R16) Boot-complete feeds interrupt logic as an event; both copies always agree.
// (R17) Register zero reads a fixed 16-bit identification code in bits 15 to 0.
// (R18) Register one reads an 8-bit read-only silicon revision code.
// (R19) Register two reads an 8-bit read-only driver revision code.
// (R20) Boot-complete flag at bit 7: 0 means booting, 1 means boot finished.
// (R21) Pin defaults reload after any reset or wake; reset pin setup survives wake.
// (R22) Reset pin and register-zero trigger pass through flops before resetting logic.
// (R23) Flags rise only after all defaults and memory reversions have been applied.
`default_nettype none

package crwi_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned IDX_W  = 14;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SOFT_RESET = 14'h0000;
  localparam logic [IDX_W-1:0] IDX_HW_REV     = 14'h0001;
  localparam logic [IDX_W-1:0] IDX_SW_REV     = 14'h0002;
  localparam logic [IDX_W-1:0] IDX_PAD_CTRL   = 14'h1ad0;
  localparam logic [IDX_W-1:0] IDX_BOOT_STS1  = 14'h1880;
  localparam logic [IDX_W-1:0] IDX_BOOT_STS2  = 14'h1980;
  // Field layout and reset values
  localparam int unsigned PAD_PU_BIT     = 1;
  localparam int unsigned PAD_PD_BIT     = 0;
  localparam logic [1:0]  PAD_CTRL_RST   = 2'h2;
  localparam int unsigned BOOT_DONE_BIT  = 7;
  localparam logic [31:0] BOOT_DONE_MASK = 32'h0000_0080;
  // Timing counts in pclk cycles
  localparam int unsigned BOOT_CYCLES_DEF = 32;
  localparam int unsigned SOFT_HOLD_DEF   = 4;

  typedef enum logic [1:0] {CRWI_KIND_HW, CRWI_KIND_SOFT, CRWI_KIND_WAKE} crwi_kind_t;
  typedef enum logic [2:0] {REG_ID, REG_HWREV, REG_SWREV, REG_PAD, REG_STS1, REG_STS2,
                            REG_NONE} crwi_reg_t;

  // Word-aligned address decode shared by read and write paths
  function automatic crwi_reg_t crwi_decode(input logic [ADDR_W-1:0] addr);
    crwi_reg_t r;
    r = REG_NONE;
    if (addr[1:0] == 2'h0)
    begin
      case (addr[ADDR_W-1:2])
        IDX_SOFT_RESET: r = REG_ID;
        IDX_HW_REV:     r = REG_HWREV;
        IDX_SW_REV:     r = REG_SWREV;
        IDX_PAD_CTRL:   r = REG_PAD;
        IDX_BOOT_STS1:  r = REG_STS1;
        IDX_BOOT_STS2:  r = REG_STS2;
        default:        r = REG_NONE;
      endcase
    end
    return r;
  endfunction
endpackage

`default_nettype wire

// ===== logic/crwi_boot_if.sv
`default_nettype none

// Hold request out to the boot sequencer, completion back
interface crwi_boot_if;
  logic hold;
  logic done;
  logic done_event;
  modport ctl (output hold, input done, input done_event);
  modport seq (input hold, output done, output done_event);
endinterface

`default_nettype wire

// ===== logic/crwi_pin_keeper.sv
`default_nettype none

// Reset pin input stage: synchroniser, pulls and bus keeper
module crwi_pin_keeper (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pad
  input  wire logic pin_in,
  input  wire logic pin_released,
  input  wire logic pullup_en,
  input  wire logic pulldown_en,
  output logic      pin_out,
  output logic      pin_oe,
  // Resolved level
  output logic      level
);
  import crwi_pkg::*;

  logic [1:0] meta;
  logic [1:0] sync;
  logic       keep_en;

  assign keep_en = pullup_en & pulldown_en; // R3

  // Two flops per pad input; reset pin starts low so power-up acts as a reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= 2'h0;
      sync <= 2'h0;
    end
    else
    begin
      meta <= {pin_released, pin_in};
      sync <= meta; // R22
    end
  end

  // Floating line: keeper holds, else a lone pull decides
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level <= 1'h0;
    else if (!sync[1])
      level <= sync[0];
    else if (keep_en)
      level <= level; // R4
    else if (pullup_en)
      level <= 1'h1;
    else if (pulldown_en)
      level <= 1'h0;
  end

  // Keeper drives the held level back onto the floating pin
  assign pin_out = level;
  assign pin_oe  = keep_en & sync[1];

  AST_KEEPER_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (keep_en && sync[1])[*2] |-> $stable(level))
    else $error("reset pin level moved while keeper held a floating line");
endmodule

`default_nettype wire

// ===== logic/crwi_boot_seq.sv
`default_nettype none

// Boot sequence timer: waits out the hold, then counts the boot length
module crwi_boot_seq #(
  parameter int BOOT_CYCLES = crwi_pkg::BOOT_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Hold and completion
  crwi_boot_if.seq   bif
);
  import crwi_pkg::*;

  typedef enum logic [1:0] {BS_HOLD, BS_RUN, BS_DONE} crwi_boot_state_t;
  localparam logic [15:0] LAST = 16'(BOOT_CYCLES - 1);
  localparam int AST_LAT = BOOT_CYCLES + 1;

  crwi_boot_state_t state;
  logic [15:0]      cnt;

  // Any hold drops the flags at once; boot restarts after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state          <= BS_HOLD;
      cnt            <= 16'h0000;
      bif.done       <= 1'h0;
      bif.done_event <= 1'h0;
    end
    else
    begin
      bif.done_event <= 1'h0;
      if (bif.hold)
      begin
        state    <= BS_HOLD;
        bif.done <= 1'h0; // R13
      end
      else
      begin
        case (state)
          BS_HOLD:
          begin
            state <= BS_RUN;
            cnt   <= 16'h0000;
          end
          BS_RUN:
          begin
            if (cnt == LAST)
            begin
              state          <= BS_DONE;
              bif.done       <= 1'h1; // R14
              bif.done_event <= 1'h1;
            end
            else
              cnt <= cnt + 16'h0001;
          end
          default: state <= state;
        endcase
      end
    end
  end

  AST_FLAGS_LOW: assert property (@(posedge pclk) disable iff (!presetn) // R13
    bif.hold |=> !bif.done)
    else $error("boot flag high during a reset hold");

  AST_BOOT_DONE: assert property (@(posedge pclk) disable iff (!presetn) // R14
    $fell(bif.hold) |-> ##[1:AST_LAT] (bif.done || bif.hold))
    else $error("boot did not finish within its length");
endmodule

`default_nettype wire

// ===== logic/crwi_reset_wake.sv
// Our own choice: the APB register port.
`default_nettype none

// Reset, sleep and wake control with identification registers on APB
module crwi_reset_wake #(
  parameter logic [15:0] DEVICE_ID   = 16'ha5c3, // Arbitrary value
  parameter logic [7:0]  SILICON_REVISION_CODE = 8'h01,    // Arbitrary value
  parameter logic [7:0]  DRIVER_REVISION_CODE = 8'h01,    // Arbitrary value
  parameter int          BOOT_CYCLES = crwi_pkg::BOOT_CYCLES_DEF,
  parameter int          SOFT_HOLD   = crwi_pkg::SOFT_HOLD_DEF
) (
  // Clock and power-on reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [crwi_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  // Reset pin pad
  input  wire logic                        reset_pin_in,
  input  wire logic                        reset_pin_released,
  output logic                             reset_pin_out,
  output logic                             reset_pin_oe,
  output logic                             reset_pin_pullup_enable,
  output logic                             reset_pin_pulldown_enable,
  // Supply monitors
  input  wire logic                        analog_supply_ok,
  input  wire logic                        io_supply_ok,
  input  wire logic                        core_supply_ok,
  // Core control
  output logic                             core_reset_n,
  output logic                             sleep_mode,
  output logic                             seq_mem_revert,
  output logic                             fw_mem_clear,
  output logic                             pin_defaults_load,
  output logic                             pin_defaults_keep_aon,
  // Boot status to interrupt logic
  output logic                             boot_complete_flag_1,
  output logic                             boot_complete_flag_2,
  output logic                             boot_done_event
);
  import crwi_pkg::*;

  localparam logic [3:0] SOFT_LOAD = 4'(SOFT_HOLD);

  crwi_boot_if bif ();

  logic [2:0] sup_meta;
  logic [2:0] sup_sync;
  logic       pin_level;
  logic       hw_reset_active;
  logic       hw_q;
  logic       sleep_q;
  logic       soft_req;
  logic [3:0] soft_cnt;
  logic       hold;
  logic       hold_q;
  logic [1:0] pad_ctrl;
  crwi_kind_t kind;
  crwi_reg_t  reg_sel;
  logic       setup_ph;
  logic       wr_fire;
  logic       core_busy;

  // Reset pin stage with pulls and keeper
  crwi_pin_keeper u_keeper (
    .pclk         (pclk),
    .presetn      (presetn),
    .pin_in       (reset_pin_in),
    .pin_released (reset_pin_released),
    .pullup_en    (pad_ctrl[PAD_PU_BIT]),
    .pulldown_en  (pad_ctrl[PAD_PD_BIT]),
    .pin_out      (reset_pin_out),
    .pin_oe       (reset_pin_oe),
    .level        (pin_level)
  );

  // Boot timer
  crwi_boot_seq #(
    .BOOT_CYCLES (BOOT_CYCLES)
  ) u_boot (
    .pclk    (pclk),
    .presetn (presetn),
    .bif     (bif.seq)
  );

  // Low resolved pin level means hardware reset, already three flops deep
  assign hw_reset_active = ~pin_level; // R1 R22

  // Supply monitors are asynchronous, so two flops before any logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sup_meta <= 3'h0;
      sup_sync <= 3'h0;
    end
    else
    begin
      sup_meta <= {core_supply_ok, io_supply_ok, analog_supply_ok};
      sup_sync <= sup_meta;
    end
  end

  // Sleep: analog and I/O present, core below threshold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sleep_mode <= 1'h0;
    else
      sleep_mode <= sup_sync[0] & sup_sync[1] & ~sup_sync[2]; // R9
  end

  // APB phases; one fixed-latency slave, so every access completes
  assign setup_ph  = psel & ~penable;
  assign wr_fire   = psel & penable & pwrite;
  assign reg_sel   = crwi_decode(paddr);
  assign pready    = 1'h1; // R8
  assign core_busy = hw_reset_active | sleep_mode;

  // Read data and error captured in setup so they come from flops in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'h0;
    end
    else if (setup_ph)
    begin
      pslverr <= (reg_sel == REG_NONE);
      case (reg_sel)
        REG_ID:    prdata <= {16'h0000, DEVICE_ID};            // R17
        REG_HWREV: prdata <= {24'h00_0000, SILICON_REVISION_CODE};       // R18
        REG_SWREV: prdata <= {24'h00_0000, DRIVER_REVISION_CODE};       // R19
        REG_PAD:   prdata <= {30'h0000_0000, pad_ctrl};
        REG_STS1:  prdata <= BOOT_DONE_MASK & {32{boot_complete_flag_1}}; // R20
        REG_STS2:  prdata <= BOOT_DONE_MASK & {32{boot_complete_flag_2}}; // R20
        default:   prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Any value written to register zero outside pin reset and sleep requests a soft reset, one flop later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_req <= 1'h0;
    else
      soft_req <= wr_fire & (reg_sel == REG_ID) & ~core_busy; // R6 R22
  end

  // Soft reset holds the core for a few cycles after the trigger
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_cnt <= 4'h0;
    else if (soft_req)
      soft_cnt <= SOFT_LOAD;
    else if (soft_cnt != 4'h0)
      soft_cnt <= soft_cnt - 4'h1;
  end

  // Combined hold; the core and boot flags stay in reset while it is high
  assign hold         = hw_reset_active | sleep_mode | soft_req | (soft_cnt != 4'h0); // R10
  assign bif.hold     = hold;
  assign core_reset_n = ~hold;

  // Pad control: reset by pin and soft reset, but always-on across sleep
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pad_ctrl <= PAD_CTRL_RST; // R2
    else if (hw_reset_active || soft_req)
      pad_ctrl <= PAD_CTRL_RST; // R1 R6
    else if (wr_fire && reg_sel == REG_PAD && pstrb[0] && !sleep_mode)
      pad_ctrl <= pwdata[1:0];
  end

  assign reset_pin_pullup_enable   = pad_ctrl[PAD_PU_BIT];
  assign reset_pin_pulldown_enable = pad_ctrl[PAD_PD_BIT];

  // Edge history for memory and pin-default pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hw_q    <= 1'h0;
      sleep_q <= 1'h0;
      hold_q  <= 1'h0;
    end
    else
    begin
      hw_q    <= hw_reset_active;
      sleep_q <= sleep_mode;
      hold_q  <= hold;
    end
  end

  // Memory reversion on pin reset or sleep entry; soft reset leaves both alone.
  // Issued while the hold is high, so boot cannot finish before it lands.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_mem_revert <= 1'h0;
      fw_mem_clear   <= 1'h0;
    end
    else
    begin
      seq_mem_revert <= (hw_reset_active & ~hw_q) | (sleep_mode & ~sleep_q); // R7 R11 R23
      fw_mem_clear   <= (hw_reset_active & ~hw_q) | (sleep_mode & ~sleep_q); // R12 R23
    end
  end

  // Reset kind, highest cause wins; wake keeps always-on pin setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      kind <= CRWI_KIND_HW;
    else if (hw_reset_active)
      kind <= CRWI_KIND_HW;
    else if (sleep_mode)
      kind <= CRWI_KIND_WAKE;
    else if (soft_req)
      kind <= CRWI_KIND_SOFT;
  end

  // Pin defaults reload as the hold releases
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_defaults_load     <= 1'h0;
      pin_defaults_keep_aon <= 1'h0;
    end
    else
    begin
      pin_defaults_load     <= hold_q & ~hold;            // R21
      pin_defaults_keep_aon <= (kind == CRWI_KIND_WAKE);  // R21
    end
  end

  // Both flag copies come from one flop, so they cannot disagree
  assign boot_complete_flag_1 = bif.done;        // R16
  assign boot_complete_flag_2 = bif.done;        // R16
  assign boot_done_event      = bif.done_event;  // R16

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_reg0_write;
    wr_fire && reg_sel == REG_ID && !core_busy;
  endsequence

  sequence s_soft_hold;
    !core_reset_n ##1 !core_reset_n ##1 !boot_complete_flag_1;
  endsequence

  sequence s_hold_release;
    !core_reset_n ##1 core_reset_n;
  endsequence

  AST_HW_PAD_DEFAULT: assert property ( // R1
    hw_reset_active |=> pad_ctrl == PAD_CTRL_RST)
    else $error("pad control not at default during pin reset");

  AST_PULLUP_AFTER_HW: assert property ( // R2
    $fell(hw_reset_active) |-> reset_pin_pullup_enable && !reset_pin_pulldown_enable)
    else $error("pull configuration wrong at pin reset release");

  AST_SOFT_WRITE: assert property ( // R6
    s_reg0_write |=> s_soft_hold)
    else $error("register zero write did not start a soft reset");

  AST_SOFT_KEEPS_SEQ: assert property ( // R7
    (soft_req && !hw_reset_active && !sleep_mode)
      |-> (!seq_mem_revert && !fw_mem_clear) ##1 (!seq_mem_revert && !fw_mem_clear))
    else $error("soft reset disturbed sequencer or firmware memory");

  AST_SLEEP_HOLD: assert property ( // R9
    (sup_sync == 3'h3) |=> sleep_mode && !core_reset_n)
    else $error("core not held in sleep");

  AST_SLEEP_AON: assert property ( // R10
    (sleep_mode && !hw_reset_active) |=> $stable(pad_ctrl))
    else $error("always-on pad control changed during sleep");

  AST_MEM_REVERT: assert property ( // R11
    ($rose(hw_reset_active) || $rose(sleep_mode)) |=> seq_mem_revert && fw_mem_clear)
    else $error("memory reversion missing after pin reset or sleep");

  AST_COPIES: assert property ( // R16
    boot_done_event |-> boot_complete_flag_1 && boot_complete_flag_2
      && !$past(boot_complete_flag_1))
    else $error("boot event not aligned with flag rise");

  AST_ID_READ: assert property ( // R17
    (setup_ph && reg_sel == REG_ID) |=> prdata == {16'h0000, DEVICE_ID} && !pslverr)
    else $error("identification read wrong");

  AST_HWREV_READ: assert property ( // R18
    (setup_ph && reg_sel == REG_HWREV) |=> prdata == {24'h00_0000, SILICON_REVISION_CODE})
    else $error("silicon revision read wrong");

  AST_REVERT_FIRST: assert property ( // R23
    seq_mem_revert |-> !boot_complete_flag_1 ##1 !boot_complete_flag_1)
    else $error("boot flag rose around a memory reversion");

  AST_SWREV_READ: assert property ( // R19
    (setup_ph && reg_sel == REG_SWREV) |=> prdata == {24'h00_0000, DRIVER_REVISION_CODE})
    else $error("driver revision read wrong");

  AST_STS_FIELD: assert property ( // R20
    (setup_ph && (reg_sel == REG_STS1 || reg_sel == REG_STS2))
      |=> (prdata & ~BOOT_DONE_MASK) == 32'h0000_0000 && !pslverr)
    else $error("status read shows bits beside the boot flag");

  AST_BUSY_NO_SOFT: assert property ( // R6
    (wr_fire && reg_sel == REG_ID && core_busy) |=> !soft_req)
    else $error("soft reset started during pin reset or sleep");

  AST_HW_FLAGS_LOW: assert property ( // R13
    hw_reset_active |=> !boot_complete_flag_1 && !boot_complete_flag_2)
    else $error("boot flags high during pin reset");

  AST_WAKE_KIND: assert property ( // R10
    ($fell(sleep_mode) && !$past(hw_reset_active)) |-> kind == CRWI_KIND_WAKE)
    else $error("wake not recorded as reset cause");

  AST_PIN_LOAD: assert property ( // R21
    s_hold_release |=> pin_defaults_load)
    else $error("pin defaults not reloaded at hold release");

  AST_AON_KEEP: assert property ( // R21
    pin_defaults_load |-> pin_defaults_keep_aon == (kind == CRWI_KIND_WAKE))
    else $error("always-on pin flag wrong at reload");

  AST_PAD_WRITE: assert property ( // R2
    (wr_fire && reg_sel == REG_PAD && pstrb[0] && !core_busy && !soft_req)
      |=> pad_ctrl == $past(pwdata[1:0]))
    else $error("pad control write lost");
endmodule

`default_nettype wire

// ===== sim/crwi_host_model.sv
`default_nettype none

// Host on the register bus: one transfer at a time, waits for pready
module crwi_host_model (
  // Clock
  input  wire logic                        pclk,
  // APB master
  output logic                             psel,
  output logic                             penable,
  output logic                             pwrite,
  output logic [crwi_pkg::ADDR_W-1:0]      paddr,
  output logic [31:0]                      pwdata,
  output logic [3:0]                       pstrb,
  input  wire logic                        pready,
  input  wire logic [31:0]                 prdata,
  input  wire logic                        pslverr,
  // Set if the slave never answered
  output logic                             hang
);
  timeunit 1ns;
  timeprecision 100ps;
  import crwi_pkg::*;

  // Idle bus at time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    pstrb   = 4'hf;
    hang    = 1'b0;
  end

  // Setup, then access held until pready; released lines show inverted values
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1)
      hang <= 1'b1;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask

  // No control writes until boot is over; status copy polled with a cap
  task automatic wait_boot(output logic ok);
    logic [31:0] q;
    logic        e;
    int          i;
    ok = 1'b0;
    repeat (4) @(posedge pclk);
    for (i = 0; i < 100 && !ok; i++)
    begin
      xfer(1'b0, {IDX_BOOT_STS1, 2'b00}, 32'h0000_0000, q, e);
      ok = (q[BOOT_DONE_BIT] === 1'b1);
    end
  endtask
endmodule

`default_nettype wire

// ===== sim/tb_top.sv
`default_nettype none

// Bench for the reset, sleep and wake control
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import crwi_pkg::*;

  localparam logic [15:0] DEV_ID = 16'h3c5a; // Arbitrary value
  localparam logic [7:0]  HW_REV = 8'h07;    // Arbitrary value
  localparam logic [7:0]  SW_REV = 8'h0b;    // Arbitrary value
  localparam logic [15:0] A_PAD  = {IDX_PAD_CTRL, 2'b00};

  typedef struct packed {logic [15:0] a; logic [31:0] d; logic e;} crwi_tb_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hang, e, ok;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        pin_in, pin_rel, ana_ok, io_ok, core_ok, pin_out, pin_oe, pu, pd;
  logic        core_rst_n, sleep, rev, clr, ld, aon, f1, f2, evt;
  int          n_errors, num_checks, n_rev, n_clr, n_evt, n_ld, r0, c0, e0, l0, i;

  // Plain reads after boot: address, word, error
  crwi_tb_row_t rows [8] = '{
    '{16'h0000, {16'h0000, DEV_ID}, 1'b0}, '{16'h0004, {24'h00_0000, HW_REV}, 1'b0},
    '{16'h0008, {24'h00_0000, SW_REV}, 1'b0}, '{A_PAD, 32'h0000_0002, 1'b0},
    '{16'h6200, 32'h0000_0080, 1'b0}, '{16'h6600, 32'h0000_0080, 1'b0},
    '{16'h000c, 32'h0000_0000, 1'b1}, '{16'h0001, 32'h0000_0000, 1'b1}};

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  crwi_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .hang(hang));

  crwi_reset_wake #(.DEVICE_ID(DEV_ID), .SILICON_REVISION_CODE(HW_REV), .DRIVER_REVISION_CODE(SW_REV),
    .BOOT_CYCLES(4), .SOFT_HOLD(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .reset_pin_in(pin_in),
    .reset_pin_released(pin_rel), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
    .reset_pin_pullup_enable(pu), .reset_pin_pulldown_enable(pd),
    .analog_supply_ok(ana_ok), .io_supply_ok(io_ok), .core_supply_ok(core_ok),
    .core_reset_n(core_rst_n), .sleep_mode(sleep), .seq_mem_revert(rev),
    .fw_mem_clear(clr), .pin_defaults_load(ld), .pin_defaults_keep_aon(aon),
    .boot_complete_flag_1(f1), .boot_complete_flag_2(f2), .boot_done_event(evt));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Pulse tally for memory reversion and boot events
  always @(posedge pclk)
  begin
    n_rev += rev;
    n_clr += clr;
    n_evt += evt;
    n_ld  += ld;
    if (presetn)
      chk({31'h0, f1}, {31'h0, f2});
  end

  // Cuts a hang short; the whole run needs fewer than two hundred cycles
  initial
  begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done;
  end

  initial
  begin
    presetn = 1'b0;
    pin_in  = 1'b1;
    pin_rel = 1'b0;
    ana_ok  = 1'b1;
    io_ok   = 1'b1;
    core_ok = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    host.wait_boot(ok);
    chk({31'h0, ok}, 32'h1);
    chk(32'(n_evt), 32'h1);
    chk(32'(n_rev), 32'h1);
    chk({30'h0, pu, pd}, 32'h2);
    for (i = 0; i < 8; i++)
    begin
      host.xfer(1'b0, rows[i].a, 32'h0000_0000, q, e);
      chk(q, rows[i].d);
      chk({31'h0, e}, {31'h0, rows[i].e});
    end
    // Software reset keeps sequencer and firmware memory
    host.xfer(1'b1, A_PAD, 32'h0000_0001, q, e);
    host.xfer(1'b0, A_PAD, 32'h0000_0000, q, e);
    chk(q, 32'h1);
    r0 = n_rev;
    c0 = n_clr;
    e0 = n_evt;
    l0 = n_ld;
    host.xfer(1'b1, 16'h0000, 32'hffff_ffff, q, e);
    repeat (2) @(posedge pclk);
    #1;
    chk({31'h0, core_rst_n}, 32'h0);
    chk({31'h0, f1}, 32'h0);
    host.wait_boot(ok);
    chk({31'h0, ok}, 32'h1);
    chk(32'(n_rev - r0), 32'h0);
    chk(32'(n_clr - c0), 32'h0);
    chk(32'(n_evt - e0), 32'h1);
    chk(32'(n_ld - l0), 32'h1);
    host.xfer(1'b0, A_PAD, 32'h0000_0000, q, e);
    chk(q, 32'h2);
    host.xfer(1'b0, 16'h0000, 32'h0000_0000, q, e);
    chk(q, {16'h0000, DEV_ID});
    // Read-only and unmapped writes
    host.xfer(1'b1, 16'h0004, 32'hffff_ffff, q, e);
    chk({31'h0, e}, 32'h0);
    host.xfer(1'b0, 16'h0004, 32'h0000_0000, q, e);
    chk(q, {24'h00_0000, HW_REV});
    host.xfer(1'b1, 16'h000c, 32'h0000_0001, q, e);
    chk({31'h0, e}, 32'h1);
    // Sleep keeps always-on pad control, reverts memories
    host.xfer(1'b1, A_PAD, 32'h0000_0001, q, e);
    r0 = n_rev;
    c0 = n_clr;
    @(posedge pclk);
    core_ok <= 1'b0;
    repeat (8) @(posedge pclk);
    #1;
    chk({30'h0, sleep, core_rst_n}, 32'h2);
    chk({31'h0, f1}, 32'h0);
    chk(32'(n_rev - r0), 32'h1);
    chk(32'(n_clr - c0), 32'h1);
    host.xfer(1'b1, A_PAD, 32'h0000_0002, q, e);
    host.xfer(1'b1, 16'h0000, 32'h0000_0001, q, e);
    @(posedge pclk);
    core_ok <= 1'b1;
    host.wait_boot(ok);
    chk({31'h0, ok}, 32'h1);
    chk({30'h0, sleep, aon}, 32'h1);
    host.xfer(1'b0, A_PAD, 32'h0000_0000, q, e);
    chk(q, 32'h1);
    // Hardware reset through the pin, seen only after synchronising; no audio bus to quiesce
    r0 = n_rev;
    c0 = n_clr;
    @(posedge pclk);
    pin_in <= 1'b0;
    @(posedge pclk);
    #1;
    chk({31'h0, core_rst_n}, 32'h1);
    repeat (8) @(posedge pclk);
    #1;
    chk({30'h0, core_rst_n, f1}, 32'h0);
    chk(32'(n_rev - r0), 32'h1);
    chk(32'(n_clr - c0), 32'h1);
    @(posedge pclk);
    pin_in <= 1'b1;
    host.wait_boot(ok);
    host.xfer(1'b0, A_PAD, 32'h0000_0000, q, e);
    chk(q, 32'h2);
    chk({31'h0, aon}, 32'h0);
    // Keeper holds the high level while the line floats low-ward
    host.xfer(1'b1, A_PAD, 32'h0000_0003, q, e);
    @(posedge pclk);
    pin_rel <= 1'b1;
    pin_in  <= 1'b0;
    repeat (8) @(posedge pclk);
    #1;
    chk({29'h0, pin_oe, pin_out, core_rst_n}, 32'h7);
    @(posedge pclk);
    pin_rel <= 1'b0;
    pin_in  <= 1'b1;
    repeat (8) @(posedge pclk);
    #1;
    chk({30'h0, pin_oe, core_rst_n}, 32'h1);
    chk({31'h0, hang}, 32'h0);
    test_done;
  end
endmodule

`default_nettype wire
